/* hdl/hybrid_regs_defines.svh */
// Register map constants for the hybrid tap and receive gain registers.
// Assumes the serial control port delivers an 8-bit address and 8-bit data.
`ifndef HYBRID_REGS_DEFINES_SVH
`define HYBRID_REGS_DEFINES_SVH
`define ADDR_TAP7       8'h33
`define ADDR_TAP8       8'h34
`define ADDR_RSVD_FIRST 8'h35
`define ADDR_RSVD_LAST  8'h3a
`define ADDR_RX_GAIN    8'h3b
`define TAP_RESET       8'h00
`define GAIN_RESET      8'h00
`define GAIN_STEP_POS   2
`define DRAW_EN_POS     1
`define GAIN_WR_MASK    8'h06
`define RSVD_READ       8'h00
`endif

/* hdl/hybrid_regs_pkg.sv */
// Types for the hybrid tap and receive gain register block.
// Assumes the defines header is included by files that need offsets.
package hybrid_regs_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [7:0] reg_addr_t;
endpackage

/* hdl/hybrid_reg_cell.sv */
// One 8-bit read/write register with a write-select and reset value.
// Assumes a single synchronous clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module hybrid_reg_cell (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  input  wire logic                     i_sel,
  input  wire hybrid_regs_pkg::reg_byte_t i_mask,
  input  wire hybrid_regs_pkg::reg_byte_t i_wdata,
  output hybrid_regs_pkg::reg_byte_t    o_value
);
  import hybrid_regs_pkg::*;

  reg_byte_t value;
  reg_byte_t next_value;

  // =====================================================
  // Storage.
  always_comb begin
    next_value = value;
    if (i_sel) begin
      next_value = i_wdata & i_mask;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      value <= 8'h00;
    end else begin
      value <= next_value;
    end
  end

  assign o_value = value;
endmodule

/* hdl/hybrid_taps_rx_gain_regs.sv */
// Hybrid taps seven and eight plus receive gain control register bank.
// Assumes a serial control port decoder hands over one-cycle write and read strobes.
//
// Behaviour
// RULE1 - Tap seven has a read/write 8-bit coefficient register feeding the filter.
// RULE2 - Tap eight has a read/write 8-bit coefficient register feeding the filter.
// RULE3 - A zero coefficient gives no filter contribution, and zero is the reset value.
// RULE4 - The host never writes the reserved addresses, whose contents are undefined.
// RULE5 - The host writes zeros to the unused bits of the receive gain register.
// RULE6 - Gain bit two cleared gives no gain, set gives one dB of receive gain.
// RULE7 - Draw enable bit one with the companion line bit draws on-hook loop current.
// RULE8 - A coefficient write changes only its own tap, from the next filter sample.
`timescale 1ns/1ps
`include "hybrid_regs_defines.svh"
module hybrid_taps_rx_gain_regs (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  input  wire hybrid_regs_pkg::reg_addr_t i_addr,
  input  wire hybrid_regs_pkg::reg_byte_t i_wdata,
  input  wire logic                       i_sample,
  input  wire logic                       i_companion_line_bit,
  input  wire logic                       i_on_hook,
  output hybrid_regs_pkg::reg_byte_t      o_rdata,
  output logic                            o_rvalid,
  output hybrid_regs_pkg::reg_byte_t      o_tap7_coeff,
  output hybrid_regs_pkg::reg_byte_t      o_tap8_coeff,
  output logic                            o_tap7_active,
  output logic                            o_tap8_active,
  output logic                            o_rx_gain_step,
  output logic                            o_loop_draw
);
  import hybrid_regs_pkg::*;

  reg_byte_t hybrid_tap7_coeff;
  reg_byte_t hybrid_tap8_coeff;
  reg_byte_t rx_gain_control;
  logic      sel7;
  logic      sel8;
  logic      selg;
  logic      comp_s1;
  logic      comp_s2;
  logic      hook_s1;
  logic      hook_s2;
  reg_byte_t rdata;
  reg_byte_t next_rdata;
  logic      rvalid;
  reg_byte_t tap7;
  reg_byte_t tap8;
  logic      act7;
  logic      act8;
  logic      gain;
  logic      draw;
  logic      next_rvalid;
  reg_byte_t next_tap7;
  reg_byte_t next_tap8;
  logic      next_act7;
  logic      next_act8;
  logic      next_gain;
  logic      next_draw;

  // =====================================================
  // Address decode.
  function automatic logic hit(input reg_addr_t a, input reg_addr_t target);
    hit = (a == target);
  endfunction

  always_comb begin
    sel7 = 1'b0;
    sel8 = 1'b0;
    selg = 1'b0;
    if (i_wr && hit(i_addr, `ADDR_TAP7)) begin
      sel7 = 1'b1; // RULE8
    end else if (i_wr && hit(i_addr, `ADDR_TAP8)) begin
      sel8 = 1'b1; // RULE8
    end else if (i_wr && hit(i_addr, `ADDR_RX_GAIN)) begin
      selg = 1'b1;
    end
  end

  // =====================================================
  // Register storage.
  hybrid_reg_cell u_tap7 (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_sel   (sel7),
    .i_mask  (8'hff),
    .i_wdata (i_wdata),
    .o_value (hybrid_tap7_coeff)
  ); // RULE1

  hybrid_reg_cell u_tap8 (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_sel   (sel8),
    .i_mask  (8'hff),
    .i_wdata (i_wdata),
    .o_value (hybrid_tap8_coeff)
  ); // RULE2

  // Unused bits are masked so they read back as zero whatever is written.
  hybrid_reg_cell u_gain (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_sel   (selg),
    .i_mask  (`GAIN_WR_MASK),
    .i_wdata (i_wdata),
    .o_value (rx_gain_control)
  ); // RULE5

  // =====================================================
  // Pin synchronisers.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      comp_s1 <= 1'b0;
      comp_s2 <= 1'b0;
      hook_s1 <= 1'b0;
      hook_s2 <= 1'b0;
    end else begin
      comp_s1 <= i_companion_line_bit;
      comp_s2 <= comp_s1;
      hook_s1 <= i_on_hook;
      hook_s2 <= hook_s1;
    end
  end

  // =====================================================
  // Read path and filter-facing outputs.
  always_comb begin
    next_rdata  = rdata;
    next_rvalid = i_rd;
    if (i_rd) begin
      if (hit(i_addr, `ADDR_TAP7)) begin
        next_rdata = hybrid_tap7_coeff;
      end else if (hit(i_addr, `ADDR_TAP8)) begin
        next_rdata = hybrid_tap8_coeff;
      end else if (hit(i_addr, `ADDR_RX_GAIN)) begin
        next_rdata = rx_gain_control;
      end else begin
        next_rdata = `RSVD_READ; // RULE4
      end
    end
    next_tap7 = tap7;
    next_tap8 = tap8;
    next_act7 = act7;
    next_act8 = act8;
    if (i_sample) begin
      next_tap7 = hybrid_tap7_coeff; // RULE8
      next_tap8 = hybrid_tap8_coeff; // RULE8
      next_act7 = |hybrid_tap7_coeff; // RULE3
      next_act8 = |hybrid_tap8_coeff; // RULE3
    end
    next_gain = rx_gain_control[`GAIN_STEP_POS]; // RULE6
    next_draw = rx_gain_control[`DRAW_EN_POS] & comp_s2 & hook_s2; // RULE7
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
      tap7   <= 8'h00;
      tap8   <= 8'h00;
      act7   <= 1'b0;
      act8   <= 1'b0;
      gain   <= 1'b0;
      draw   <= 1'b0;
    end else begin
      rdata  <= next_rdata;
      rvalid <= next_rvalid;
      tap7   <= next_tap7;
      tap8   <= next_tap8;
      act7   <= next_act7;
      act8   <= next_act8;
      gain   <= next_gain;
      draw   <= next_draw;
    end
  end

  assign o_rdata        = rdata;
  assign o_rvalid       = rvalid;
  assign o_tap7_coeff   = tap7;
  assign o_tap8_coeff   = tap8;
  assign o_tap7_active  = act7;
  assign o_tap8_active  = act8;
  assign o_rx_gain_step = gain;
  assign o_loop_draw    = draw;

  // =====================================================
  // Assertions.
  sequence s_write7;
    i_wr && i_addr == `ADDR_TAP7;
  endsequence

  tap7_write_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE1
    s_write7 ##1 1'b1 |-> hybrid_tap7_coeff == $past(i_wdata))
    else $error("tap seven write not stored");

  tap8_write_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE2
    i_wr && i_addr == `ADDR_TAP8 |=> hybrid_tap8_coeff == $past(i_wdata))
    else $error("tap eight write not stored");

  zero_tap_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE3
    i_sample && hybrid_tap7_coeff == 8'h00 |=> !o_tap7_active)
    else $error("zero tap marked active");

  gain_bit_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE6
    selg |-> ##2 o_rx_gain_step == $past(i_wdata[`GAIN_STEP_POS], 2))
    else $error("gain step does not follow write");

  draw_enable_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE7
    !rx_gain_control[`DRAW_EN_POS] |=> !o_loop_draw)
    else $error("loop draw without enable");

  tap_isolation_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE8
    sel7 |=> $stable(hybrid_tap8_coeff))
    else $error("tap eight disturbed by tap seven write");

  sample_hold_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE8
    !i_sample |=> $stable(o_tap7_coeff))
    else $error("tap seven changed between samples");

  reserved_read_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE4
    i_rd && i_addr >= `ADDR_RSVD_FIRST && i_addr <= `ADDR_RSVD_LAST |=> o_rdata == 8'h00)
    else $error("reserved read not zero");
endmodule

/* tb/host_model.sv */
// Host model that drives the register strobes of the hybrid tap bank.
// Assumes one shared clock; requests change 1 ns after a rising edge.
`timescale 1ns/1ps
`include "hybrid_regs_defines.svh"
module host_model (
  input  wire logic       i_clk,
  output logic            o_wr,
  output logic            o_rd,
  output logic [7:0]      o_addr,
  output logic [7:0]      o_wdata
);
  // ==========================================================
  // Bus tasks.
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    if (a >= `ADDR_RSVD_FIRST && a <= `ADDR_RSVD_LAST) return;
    @(posedge i_clk) #1;
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = (a == `ADDR_RX_GAIN) ? (d & `GAIN_WR_MASK) : d;
    @(posedge i_clk) #1;
    o_wr = 1'b0;
    o_wdata = ~o_wdata;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge i_clk) #1;
    o_rd = 1'b1;
    o_addr = a;
    @(posedge i_clk) #1;
    o_rd = 1'b0;
    o_addr = ~a;
  endtask
endmodule

/* tb/tb_hybrid_taps_rx_gain_regs.sv */
// Self-checking bench for the hybrid tap and receive gain registers.
// Assumes host_model drives the strobes; read results are queued notes.
`timescale 1ns/1ps
`include "hybrid_regs_defines.svh"
module tb_hybrid_taps_rx_gain_regs;
  import hybrid_regs_pkg::*;
  logic        i_clk = 0, i_rst = 1, smp_p = 0, comp = 0, hook = 0;
  logic        wr, rd, rvalid, act7, act8, gain, draw;
  reg_addr_t   addr;
  reg_byte_t   wdata, rdata, t7, t8, e7, e8, g;
  reg_byte_t   expq[$];
  int          err_count = 0, tests_run = 0;
  logic [31:0] seed = 32'hef8722ad;
  host_model h (.i_clk(i_clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
  hybrid_taps_rx_gain_regs dut (.i_clk(i_clk), .i_rst(i_rst), .i_wr(wr), .i_rd(rd),
    .i_addr(addr), .i_wdata(wdata), .i_sample(smp_p), .i_companion_line_bit(comp),
    .i_on_hook(hook), .o_rdata(rdata), .o_rvalid(rvalid), .o_tap7_coeff(t7),
    .o_tap8_coeff(t8), .o_tap7_active(act7), .o_tap8_active(act8),
    .o_rx_gain_step(gain), .o_loop_draw(draw));
  // ==========================================================
  // Helpers.
  initial forever #2 i_clk = ~i_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input reg_byte_t seen, input reg_byte_t exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic rd_exp(input reg_addr_t a, input reg_byte_t e);
    expq.push_back(e);
    h.rd_reg(a);
  endtask
  task automatic sample;
    @(posedge i_clk) #1;
    smp_p = 1'b1;
    @(posedge i_clk) #1;
    smp_p = 1'b0;
  endtask
  task automatic end_sim;
    chk(8'(expq.size()), 8'h00);
    $display("tests %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Read results are taken mid-cycle, where the registered outputs have settled.
  always @(negedge i_clk) begin
    if (rvalid === 1'b1) chk(rdata, expq.pop_front());
  end
  initial begin
    #20000;
    err_count++;
    end_sim();
  end
  // ==========================================================
  // Tests.
  initial begin
    repeat (16) @(posedge i_clk);
    #1 i_rst = 1'b0;
    for (int a = 8'h33; a <= 8'h3b; a++) rd_exp(8'(a), 8'h00);
    sample();
    chk(t7, 8'h00);
    chk({7'h0, act8}, 8'h00);
    $display("reset test done");
    e7 = 8'h00;
    e8 = 8'h00;
    repeat (10) begin
      seed = xs(seed);
      e7 = seed[7:0];
      h.wr_reg(`ADDR_TAP7, e7);
      if (seed[16]) e8 = seed[15:8];
      if (seed[16]) h.wr_reg(`ADDR_TAP8, e8);
      rd_exp(`ADDR_TAP7, e7);
      rd_exp(`ADDR_TAP8, e8);
      sample();
      chk(t7, e7);
      chk(t8, e8);
      chk({7'h0, act7}, {7'h0, |e7});
      chk({7'h0, act8}, {7'h0, |e8});
      h.wr_reg(`ADDR_TAP7, 8'h00);
      chk(t7, e7);
      sample();
      chk({7'h0, act7}, 8'h00);
    end
    $display("tap test done");
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      g = {5'h0, 2'(k), 1'b0};
      h.wr_reg(`ADDR_RX_GAIN, seed[7:0] & 8'hf9 | g);
      rd_exp(`ADDR_RX_GAIN, g);
      chk({7'h0, gain}, {7'h0, g[2]});
      for (int c = 0; c < 4; c++) begin
        comp = c[0];
        hook = c[1];
        repeat (6) @(posedge i_clk);
        #1;
        chk({7'h0, draw}, {7'h0, g[1] & comp & hook});
      end
    end
    $display("gain test done");
    repeat (4) @(posedge i_clk);
    end_sim();
  end
endmodule
